// file: hdl/ued_device.sv
// usb module end: token to descriptor fetch, service and write-back
//
// Contract
// - software aligns table to 512 bytes, loads page
// - two eight-byte entries per endpoint direction
// - table at most 512 bytes, sixteen endpoints
// - own bit zero cpu, one usb module
// - cpu leaves owned entries and buffers alone
// - token on enabled endpoint fetches entry, checks own
// - per direction odd selector alternates the entries
// - address is page, endpoint, tx, odd
// - tx bit one transmit, zero receive
// - out and setup receive, in transmits
// - ten bit byte count at 57:48
// - bits 31:0 hold buffer pointer
// - bit 39 own, bit 38 data toggle
// - bits 37:34 control bits or token pid
// - keep and no increment taken from entry
// - completion clears own unless keep set
// - keep clear writes token pid back
// - cpu writes own byte last
`timescale 1ns/1ns
module ued_device
  import ued_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              sys_rst_in,
  ued_if.dev                     link,
  input  wire logic              token_valid_in,
  input  wire logic [3:0]        token_ep_in,
  input  wire logic [3:0]        token_pid_in,
  input  wire logic [NUM_EP-1:0] ep_rx_en_in,
  input  wire logic [NUM_EP-1:0] ep_tx_en_in,
  input  wire logic [NUM_EP-1:0] ep_ctl_dis_in,
  input  wire logic              xfer_step_in,
  input  wire logic              xfer_done_in,
  input  wire logic [BC_W-1:0]   xfer_count_in,
  output logic                   busy_out,
  output logic                   entry_live_out,
  output logic                   tx_out,
  output logic                   odd_out,
  output logic [31:0]            buf_addr_out,
  output logic [BC_W-1:0]        byte_count_out,
  output logic                   data_toggle_out,
  output logic                   no_inc_out,
  output logic                   toggle_sync_out,
  output logic                   stall_out,
  output logic                   done_out,
  output logic                   nak_out
);
  ued_state_t        state_r;
  logic [3:0]        ep_r;
  logic [3:0]        pid_r;
  logic              tx_r;
  logic [31:0]       ctl_r;
  logic [BC_W-1:0]   count_r;
  logic              req_r;
  logic              we_r;
  logic [31:0]       addr_r;
  logic [31:0]       wdata_r;

  wire               is_in      = (token_pid_in == PID_IN);
  wire               is_out     = (token_pid_in == PID_OUT);
  wire               is_setup   = (token_pid_in == PID_SETUP);
  // setup needs both directions and control transfers not disabled
  wire               tok_ok     = token_valid_in && (state_r == ST_IDLE) &&
                                  ((is_in && ep_tx_en_in[token_ep_in]) ||
                                   (is_out && ep_rx_en_in[token_ep_in]) ||
                                   (is_setup && ep_rx_en_in[token_ep_in] && ep_tx_en_in[token_ep_in] &&
                                    !ep_ctl_dis_in[token_ep_in]));
  wire               tok_tx     = is_in;
  wire [3:0]         sel_ep     = (state_r == ST_IDLE) ? token_ep_in : ep_r;
  wire               sel_tx     = (state_r == ST_IDLE) ? tok_tx : tx_r;
  wire [4:0]         dir_idx    = {sel_ep, sel_tx};
  wire               odd_sel;
  wire               ack        = link.mem_ack && req_r;
  // entry base: 16 bytes per direction, 8 per entry
  wire [31:0]        entry_base = {link.table_base_page, sel_ep, sel_tx, odd_sel, 3'h0};
  wire               own_rd     = link.mem_rdata[OWN_BIT];
  wire               keep       = ctl_r[KEEP_BIT];
  wire [3:0]         pid_field  = keep ? ctl_r[KEEP_BIT:STALL_BIT] : pid_r;
  wire               own_wb     = keep;
  wire [31:0]        wb_word    = {6'h00, xfer_count_in, 8'h00, own_wb, ctl_r[TOGGLE_BIT], pid_field,
                                   2'h0};
  wire               flip       = (state_r == ST_WB) && ack;
  wire [31:0]        step_addr  = buf_addr_out + 32'h00000001;

  ued_odd_bank #(
    .N  (NUM_DIR),
    .IW (5)
  ) u_odd_bank (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .sel_idx_in (dir_idx),
    .flip_in    (flip),
    .odd_out    (odd_sel)
  );

  assign link.mem_req   = req_r;
  assign link.mem_we    = we_r;
  assign link.mem_addr  = addr_r;
  assign link.mem_wdata = wdata_r;

  // sequencer
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      state_r <= ST_IDLE;
      req_r   <= 1'b0;
      we_r    <= 1'b0;
      addr_r  <= WORD_RST;
      wdata_r <= WORD_RST;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (tok_ok)
          begin
            state_r <= ST_RD_CTL;
            req_r   <= 1'b1;
            we_r    <= 1'b0;
            addr_r  <= entry_base | {29'h0, CTL_WORD_OFS};
          end
        end
        ST_RD_CTL:
        begin
          if (ack && !own_rd)
          begin
            state_r <= ST_IDLE;
            req_r   <= 1'b0;
          end
          else if (ack)
          begin
            state_r <= ST_RD_PTR;
            addr_r  <= entry_base | {29'h0, PTR_WORD_OFS};
          end
        end
        ST_RD_PTR:
        begin
          if (ack)
          begin
            state_r <= ST_XFER;
            req_r   <= 1'b0;
          end
        end
        ST_XFER:
        begin
          if (xfer_done_in)
          begin
            state_r <= ST_WB;
            req_r   <= 1'b1;
            we_r    <= 1'b1;
            addr_r  <= entry_base | {29'h0, CTL_WORD_OFS};
            wdata_r <= wb_word;
          end
        end
        ST_WB:
        begin
          if (ack)
          begin
            state_r <= ST_IDLE;
            req_r   <= 1'b0;
            we_r    <= 1'b0;
          end
        end
      endcase
    end
  end

  // token capture and write-back fields
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      ep_r    <= 4'h0;
      pid_r   <= 4'h0;
      tx_r    <= 1'b0;
      ctl_r   <= WORD_RST;
      count_r <= '0;
    end
    else
    begin
      if (tok_ok)
      begin
        ep_r  <= token_ep_in;
        pid_r <= token_pid_in;
        tx_r  <= tok_tx;
      end
      if ((state_r == ST_RD_CTL) && ack)
      begin
        ctl_r   <= link.mem_rdata;
        count_r <= link.mem_rdata[BC_LSB +: BC_W];
      end
    end
  end

  // user side view of the live entry
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      busy_out        <= 1'b0;
      entry_live_out  <= 1'b0;
      tx_out          <= 1'b0;
      odd_out         <= 1'b0;
      buf_addr_out    <= WORD_RST;
      byte_count_out  <= '0;
      data_toggle_out <= 1'b0;
      no_inc_out      <= 1'b0;
      toggle_sync_out <= 1'b0;
      stall_out       <= 1'b0;
      done_out        <= 1'b0;
      nak_out         <= 1'b0;
    end
    else
    begin
      busy_out <= (state_r == ST_IDLE) ? tok_ok :
                  !(((state_r == ST_WB) && ack) || ((state_r == ST_RD_CTL) && ack && !own_rd));
      done_out <= flip;
      nak_out  <= (state_r == ST_RD_CTL) && ack && !own_rd;
      if (tok_ok)
      begin
        tx_out  <= tok_tx;
        odd_out <= odd_sel;
      end
      if ((state_r == ST_RD_PTR) && ack)
      begin
        entry_live_out  <= 1'b1;
        buf_addr_out    <= link.mem_rdata;
        byte_count_out  <= count_r;
        data_toggle_out <= ctl_r[TOGGLE_BIT];
        no_inc_out      <= ctl_r[NO_ADDRESS_INCREMENT_BIT_BIT];
        toggle_sync_out <= ctl_r[DTS_BIT];
        stall_out       <= ctl_r[STALL_BIT];
      end
      else if ((state_r == ST_XFER) && xfer_done_in)
        entry_live_out <= 1'b0;
      else if ((state_r == ST_XFER) && xfer_step_in && !no_inc_out)
        buf_addr_out <= step_addr;
    end
  end
endmodule : ued_device

// file: hdl/ued_host.sv
// processor and system memory end: table store, page register, cpu port
`timescale 1ns/1ns
module ued_host
  import ued_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              sys_rst_in,
  ued_if.mem                     link,
  input  wire logic              page_we_in,
  input  wire logic [PAGE_W-1:0] page_in,
  input  wire logic              cpu_req_in,
  input  wire logic              cpu_we_in,
  input  wire logic [WIDX_W-1:0] cpu_widx_in,
  input  wire logic [31:0]       cpu_wdata_in,
  output logic                   cpu_ack_out,
  output logic                   cpu_err_out,
  output logic [31:0]            cpu_rdata_out
);
  logic [31:0]       table_mem [TABLE_WORDS];
  logic [PAGE_W-1:0] page_r;
  logic              dev_ack_r;
  logic [31:0]       dev_rdata_r;

  wire [WIDX_W-1:0]  dev_widx   = link.mem_addr[WIDX_W+1:2];
  wire               dev_hit    = (link.mem_addr[31:9] == page_r);
  wire               dev_take   = link.mem_req && !dev_ack_r;
  wire               cpu_take   = cpu_req_in && !cpu_ack_out && !dev_take;
  // own bit lives in the control word of the addressed entry
  wire [WIDX_W-1:0]  ctl_widx   = {cpu_widx_in[WIDX_W-1:1], 1'b1};
  wire               entry_own  = table_mem[ctl_widx][OWN_BIT];
  wire               cpu_refuse = cpu_we_in && entry_own;
  wire               cpu_write  = cpu_take && cpu_we_in && !entry_own;

  assign link.mem_ack         = dev_ack_r;
  assign link.mem_rdata       = dev_rdata_r;
  assign link.table_base_page = page_r;

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      page_r <= PAGE_RST;
    else if (page_we_in)
      page_r <= page_in;
  end

  // cleared at reset so no entry starts owned; device has priority
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      for (int unsigned i = 0; i < TABLE_WORDS; i++)
        table_mem[i] <= WORD_RST;
    end
    else if (dev_take && link.mem_we && dev_hit)
      table_mem[dev_widx] <= link.mem_wdata;
    else if (cpu_write)
      table_mem[cpu_widx_in] <= cpu_wdata_in;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      dev_ack_r     <= 1'b0;
      dev_rdata_r   <= WORD_RST;
      cpu_ack_out   <= 1'b0;
      cpu_err_out   <= 1'b0;
      cpu_rdata_out <= WORD_RST;
    end
    else
    begin
      dev_ack_r   <= dev_take;
      dev_rdata_r <= dev_hit ? table_mem[dev_widx] : WORD_RST;
      cpu_ack_out <= cpu_take;
      cpu_err_out <= cpu_take && cpu_refuse;
      if (cpu_take && !cpu_we_in)
        cpu_rdata_out <= table_mem[cpu_widx_in];
    end
  end
endmodule : ued_host

// file: hdl/ued_if.sv
// dma link between the usb module and shared system memory
`timescale 1ns/1ns
interface ued_if;
  import ued_pkg::*;
  logic                  mem_req;
  logic                  mem_we;
  logic [31:0]           mem_addr;
  logic [31:0]           mem_wdata;
  logic                  mem_ack;
  logic [31:0]           mem_rdata;
  logic [PAGE_W-1:0]     table_base_page;

  modport dev (
    output mem_req, mem_we, mem_addr, mem_wdata,
    input  mem_ack, mem_rdata, table_base_page
  );
  modport mem (
    input  mem_req, mem_we, mem_addr, mem_wdata,
    output mem_ack, mem_rdata, table_base_page
  );
endinterface : ued_if

// file: hdl/ued_odd_bank.sv
// per endpoint direction odd/even selector bits
`timescale 1ns/1ns
module ued_odd_bank #(
  parameter int unsigned N  = 32,
  parameter int unsigned IW = 5
) (
  input  wire logic          sys_clk_in,
  input  wire logic          sys_rst_in,
  input  wire logic [IW-1:0] sel_idx_in,
  input  wire logic          flip_in,
  output logic               odd_out
);
  logic [N-1:0] bank_r;

  assign odd_out = bank_r[sel_idx_in];

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      bank_r <= '0;
    else if (flip_in)
      bank_r[sel_idx_in] <= ~bank_r[sel_idx_in];
  end
endmodule : ued_odd_bank

// file: hdl/ued_pkg.sv
// shared constants and types for the endpoint descriptor table logic
package ued_pkg;
  localparam int unsigned NUM_EP          = 16;
  localparam int unsigned NUM_DIR         = 32;
  localparam int unsigned ENTRY_BYTES     = 8;
  localparam int unsigned TABLE_BYTES     = 512;
  localparam int unsigned TABLE_WORDS     = TABLE_BYTES / 4;
  localparam int unsigned PAGE_W          = 23;
  localparam int unsigned WIDX_W          = 7;
  localparam int unsigned BC_W            = 10;
  // entry address layout: page | endpoint | tx | odd | byte in entry
  localparam int unsigned ADDR_EP_LSB     = 5;
  localparam int unsigned ADDR_TX_BIT     = 4;
  localparam int unsigned ADDR_ODD_BIT    = 3;
  localparam logic [2:0]  PTR_WORD_OFS    = 3'h0;
  localparam logic [2:0]  CTL_WORD_OFS    = 3'h4;
  // fields of the control word (entry bits 63:32, less 32)
  localparam int unsigned OWN_BIT         = 7;
  localparam int unsigned TOGGLE_BIT      = 6;
  localparam int unsigned KEEP_BIT        = 5;
  localparam int unsigned NO_ADDRESS_INCREMENT_BIT_BIT        = 4;
  localparam int unsigned DTS_BIT         = 3;
  localparam int unsigned STALL_BIT       = 2;
  localparam int unsigned PID_LSB         = 2;
  localparam int unsigned BC_LSB          = 16;
  // token pids
  localparam logic [3:0]  PID_OUT         = 4'h1;
  localparam logic [3:0]  PID_IN          = 4'h9;
  localparam logic [3:0]  PID_SETUP       = 4'hd;
  // reset values
  localparam logic [PAGE_W-1:0] PAGE_RST  = 23'h000000;
  localparam logic [31:0] WORD_RST        = 32'h00000000;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_RD_CTL = 5'b00010,
    ST_RD_PTR = 5'b00100,
    ST_XFER   = 5'b01000,
    ST_WB     = 5'b10000
  } ued_state_t;
endpackage : ued_pkg

// file: sim/test_usb_endpoint_descriptor_dma.sv
// bench joining device and memory ends of the descriptor table link
`timescale 1ns/1ns
module test_usb_endpoint_descriptor_dma
  import ued_pkg::*;
;
  logic              sys_clk_in = 1'b0;
  logic              sys_rst_in = 1'b1;
  logic              token_valid_in = 1'b0;
  logic [3:0]        token_ep_in = 4'h0;
  logic [3:0]        token_pid_in = 4'h0;
  logic [NUM_EP-1:0] ep_rx_en_in = 16'h0001;
  logic [NUM_EP-1:0] ep_tx_en_in = 16'h0009;
  logic [NUM_EP-1:0] ep_ctl_dis_in = 16'h0000;
  logic              xfer_step_in = 1'b0;
  logic              xfer_done_in = 1'b0;
  logic [BC_W-1:0]   xfer_count_in = 10'h000;
  logic              page_we_in = 1'b0;
  logic [PAGE_W-1:0] page_in = 23'h000123;
  logic              cpu_req_in = 1'b0;
  logic              cpu_we_in = 1'b0;
  logic [WIDX_W-1:0] cpu_widx_in = 7'h00;
  logic [31:0]       cpu_wdata_in = 32'h00000000;
  logic              busy_out, entry_live_out, tx_out, odd_out, data_toggle_out, no_inc_out, er;
  logic              toggle_sync_out, stall_out, done_out, nak_out, cpu_ack_out, cpu_err_out;
  logic [31:0]       buf_addr_out, cpu_rdata_out, rd;
  logic [BC_W-1:0]   byte_count_out;
  int                miscompares = 0;
  int                checks = 0;
  ued_if i_ued_if ();
  ued_device i_ued_device (.sys_clk_in, .sys_rst_in, .link(i_ued_if.dev), .token_valid_in, .token_ep_in,
    .token_pid_in, .ep_rx_en_in, .ep_tx_en_in, .ep_ctl_dis_in, .xfer_step_in, .xfer_done_in, .xfer_count_in,
    .busy_out, .entry_live_out, .tx_out, .odd_out, .buf_addr_out, .byte_count_out, .data_toggle_out,
    .no_inc_out, .toggle_sync_out, .stall_out, .done_out, .nak_out);
  ued_host i_ued_host (.sys_clk_in, .sys_rst_in, .link(i_ued_if.mem), .page_we_in, .page_in, .cpu_req_in,
    .cpu_we_in, .cpu_widx_in, .cpu_wdata_in, .cpu_ack_out, .cpu_err_out, .cpu_rdata_out);
  ued_monitor i_ued_monitor (.sys_clk_in, .sys_rst_in, .mem_req(i_ued_if.mem_req), .mem_we(i_ued_if.mem_we),
    .mem_addr(i_ued_if.mem_addr), .mem_wdata(i_ued_if.mem_wdata), .mem_ack(i_ued_if.mem_ack),
    .mem_rdata(i_ued_if.mem_rdata), .table_base_page(i_ued_if.table_base_page));
  always #50 sys_clk_in = ~sys_clk_in;
  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cpu(input logic we, input logic [WIDX_W-1:0] idx, input logic [31:0] d);
    int n;
    @(posedge sys_clk_in);
    cpu_req_in <= 1'b1;
    cpu_we_in <= we;
    cpu_widx_in <= idx;
    cpu_wdata_in <= d;
    n = 0;
    @(posedge sys_clk_in);
    while (cpu_ack_out !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk_in);
      n++;
    end
    cpu_req_in <= 1'b0;
    rd = cpu_rdata_out;
    er = cpu_err_out;
    if (cpu_ack_out !== 1'b1) cmp(32'h0, 32'h1);
  endtask : cpu
  task automatic wt(input int w);
    int   n;
    logic f;
    n = 0;
    f = 1'b0;
    while (f !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk_in);
      n++;
      f = (w == 0) ? entry_live_out : (w == 1) ? done_out : nak_out;
    end
    if (f !== 1'b1) cmp(32'h0, 32'h1);
  endtask : wt
  task automatic tok(input logic [3:0] ep, input logic [3:0] pid);
    @(posedge sys_clk_in);
    token_valid_in <= 1'b1;
    token_ep_in <= ep;
    token_pid_in <= pid;
    @(posedge sys_clk_in);
    token_valid_in <= 1'b0;
  endtask : tok
  task automatic strobe(input logic stp);
    @(posedge sys_clk_in);
    xfer_step_in <= stp;
    xfer_done_in <= !stp;
    @(posedge sys_clk_in);
    xfer_step_in <= 1'b0;
    xfer_done_in <= 1'b0;
  endtask : strobe
  task automatic xact(input logic [3:0] ep, input logic [3:0] pid, input logic odd, input logic [31:0] ptr,
                      input logic [31:0] ctl, input logic [9:0] cnt);
    logic              tx;
    logic [WIDX_W-1:0] idx;
    tx = pid == PID_IN;
    idx = {ep, tx, odd, 1'b0};
    cpu(1'b1, idx | 7'h01, 32'h0);
    cpu(1'b1, idx, ptr);
    cpu(1'b1, idx | 7'h01, ctl);
    cmp({31'h0, er}, 32'h0);
    tok(ep, pid);
    wt(0);
    cmp({byte_count_out, 14'h0, busy_out, entry_live_out, tx_out, odd_out, data_toggle_out, no_inc_out,
         toggle_sync_out, stall_out},
        {ctl[25:16], 14'h0, 2'b11, tx, odd, ctl[6], ctl[4:2]});
    strobe(1'b1);
    strobe(1'b1);
    @(posedge sys_clk_in);
    cmp(buf_addr_out, ptr + (ctl[NO_ADDRESS_INCREMENT_BIT_BIT] ? 32'h0 : 32'h2));
    xfer_count_in <= cnt;
    strobe(1'b0);
    wt(1);
    cmp({30'h0, busy_out, entry_live_out}, 32'h0);
    cpu(1'b0, idx | 7'h01, 32'h0);
    cmp(rd, {6'h0, cnt, 8'h0, ctl[KEEP_BIT], ctl[6], ctl[KEEP_BIT] ? ctl[5:2] : pid, 2'h0});
    cpu(1'b0, idx, 32'h0);
    cmp(rd, ptr);
  endtask : xact
  initial
  begin
    repeat (5) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    cmp({29'h0, busy_out, odd_out, entry_live_out}, 32'h0);
    page_we_in <= 1'b1;
    @(posedge sys_clk_in);
    page_we_in <= 1'b0;
    xact(4'h3, PID_IN, 1'b0, 32'h00001000, 32'h03ff00c8, 10'h005);
    xact(4'h3, PID_IN, 1'b1, 32'h00002000, 32'h000100b4, 10'h3ff);
    cpu(1'b1, 7'h1e, 32'h0);
    cmp({31'h0, er}, 32'h1);
    tok(4'h3, PID_IN);
    wt(2);
    xact(4'h3, PID_IN, 1'b0, 32'h00003000, 32'h00000080, 10'h000);
    xact(4'h0, PID_OUT, 1'b0, 32'hfffffffe, 32'h00400080, 10'h040);
    xact(4'h0, PID_SETUP, 1'b1, 32'h00000100, 32'h02000088, 10'h200);
    ep_ctl_dis_in <= 16'h0001;
    tok(4'h0, PID_SETUP);
    @(posedge sys_clk_in);
    cmp({31'h0, busy_out}, 32'h0);
    tok(4'h5, PID_IN);
    @(posedge sys_clk_in);
    cmp({31'h0, busy_out}, 32'h0);
    results;
  end
  initial
  begin
    #1000000;
    cmp(32'h0, 32'h1);
    results;
  end
endmodule : test_usb_endpoint_descriptor_dma

// file: sim/ued_monitor.sv
// link assertions for the descriptor table dma
`timescale 1ns/1ns
module ued_monitor
  import ued_pkg::*;
(
  input wire logic              sys_clk_in,
  input wire logic              sys_rst_in,
  input wire logic              mem_req,
  input wire logic              mem_we,
  input wire logic [31:0]       mem_addr,
  input wire logic [31:0]       mem_wdata,
  input wire logic              mem_ack,
  input wire logic [31:0]       mem_rdata,
  input wire logic [PAGE_W-1:0] table_base_page
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [31:0] ctl_r;
  logic [31:0] addr_r;
  wire         ctl_rd = mem_ack && !mem_we && mem_addr[2:0] == CTL_WORD_OFS;
  always_ff @(posedge sys_clk_in)
  begin
    if (ctl_rd)
    begin
      ctl_r  <= mem_rdata;
      addr_r <= mem_addr;
    end
  end
  property p_req_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  property p_ack_next;
    mem_req && !mem_ack |=> mem_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("memory ack late");
  property p_ack_pulse;
    mem_ack |=> !mem_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_page;
    mem_req |-> mem_addr[31:9] == table_base_page;
  endproperty
  a_page: assert property (p_page) else $error("entry address outside table page");
  property p_first_ctl;
    $rose(mem_req) |-> mem_addr[2:0] == CTL_WORD_OFS;
  endproperty
  a_first_ctl: assert property (p_first_ctl) else $error("first access not control word");
  property p_ptr_next;
    ctl_rd && mem_rdata[OWN_BIT] |=> mem_req && !mem_we && mem_addr == {addr_r[31:3], PTR_WORD_OFS};
  endproperty
  a_ptr_next: assert property (p_ptr_next) else $error("pointer word not fetched");
  property p_nak_stop;
    ctl_rd && !mem_rdata[OWN_BIT] |=> !mem_req;
  endproperty
  a_nak_stop: assert property (p_nak_stop) else $error("entry used while cpu owns it");
  property p_wb_ctl;
    mem_req && mem_we |-> mem_addr == addr_r && mem_wdata[OWN_BIT] == ctl_r[KEEP_BIT]
      && mem_wdata[TOGGLE_BIT] == ctl_r[TOGGLE_BIT] && mem_wdata[15:8] == 8'h00 && mem_wdata[1:0] == 2'h0;
  endproperty
  a_wb_ctl: assert property (p_wb_ctl) else $error("bad write-back word");
  property p_wb_keep;
    mem_req && mem_we && ctl_r[KEEP_BIT] |-> mem_wdata[5:2] == ctl_r[5:2];
  endproperty
  a_wb_keep: assert property (p_wb_keep) else $error("kept entry control bits changed");
  c_nak: cover property (ctl_rd && !mem_rdata[OWN_BIT]);
  c_wb_keep: cover property (mem_ack && mem_we && ctl_r[KEEP_BIT]);
  c_wb_rel: cover property (mem_ack && mem_we && !ctl_r[KEEP_BIT]);
endmodule : ued_monitor
